// [port_cfg_pkg.sv]
// package with register map, field layout and types of the port block
package port_cfg_pkg;

	// ***********************************
	// register map (register indexes, byte address is four times)
	// ***********************************
	// 0x8f is not a multiple of four, so printed offsets are indexes
	localparam logic [7:0] idx_port0_value       = 8'h80;
	localparam logic [7:0] idx_port3_pin_mode_config = 8'h8f;
	localparam logic [7:0] idx_port1_value       = 8'h90;
	localparam logic [7:0] idx_port2_value       = 8'ha0;
	localparam logic [7:0] idx_port3_value       = 8'hb0;

	localparam int         addr_width            = 12;
	localparam int         word_shift            = 2;

	// ***********************************
	// reset values and field layout
	// ***********************************
	localparam logic [7:0] port_value_reset      = 8'hff;
	localparam logic [7:0] config_reset          = 8'h00;
	localparam int         mode_hi               = 7;
	localparam int         mode_lo               = 5;
	localparam int         dir_bit               = 4;
	localparam int         latch_bit             = 3;
	localparam int         index_hi              = 2;
	localparam int         index_lo              = 0;
	localparam int         pin_count             = 7;
	localparam logic [2:0] index_reserved        = 3'h7;

	// ***********************************
	// mode codes
	// ***********************************
	localparam logic [2:0] out_normal            = 3'h0;
	localparam logic [2:0] out_high              = 3'h3;
	localparam logic [1:0] in_plain              = 2'h0;
	localparam logic [1:0] in_pull_down          = 2'h1;
	localparam logic [1:0] in_pull_up            = 2'h2;
	localparam logic [1:0] in_off                = 2'h3;

	typedef struct packed {
		logic [6:0] high_drive;
		logic [6:0] input_enable;
		logic [6:0] pull_down;
		logic [6:0] pull_up;
	} pin_controls_t;

endpackage

// [port_pin_mode_config.sv]
// pin mode configuration and port value registers behind an apb slave
module port_pin_mode_config
	import port_cfg_pkg::*;
#(
	parameter int port_width = 8
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [addr_width-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [port_width-1:0] port0_in,
	input  wire logic [port_width-1:0] port1_in,
	input  wire logic [port_width-1:0] port2_in,
	input  wire logic [port_width-1:0] port3_in,
	output logic      [port_width-1:0] port0_out,
	output logic      [port_width-1:0] port1_out,
	output logic      [port_width-1:0] port2_out,
	output logic      [port_width-1:0] port3_out,
	output logic      [2:0]            port3_out_mode [pin_count],
	output logic      [1:0]            port3_in_mode  [pin_count],
	output port_cfg_pkg::pin_controls_t port3_controls
);

	// ***********************************
	// pin input synchronisers
	// ***********************************
	logic [port_width-1:0] sync1 [4];
	logic [port_width-1:0] sync2 [4];
	logic [port_width-1:0] sync3 [4];
	logic [port_width-1:0] pin_level [4];
	wire  [port_width-1:0] pins_raw [4];

	assign pins_raw[0] = port0_in;
	assign pins_raw[1] = port1_in;
	assign pins_raw[2] = port2_in;
	assign pins_raw[3] = port3_in;

	// a change counts only when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < 4; p++) begin
				// idle at the port reset level: no false pin change
				sync1[p]     <= port_width'(port_value_reset);
				sync2[p]     <= port_width'(port_value_reset);
				sync3[p]     <= port_width'(port_value_reset);
				pin_level[p] <= port_width'(port_value_reset);
			end
		end else begin
			for (int p = 0; p < 4; p++) begin
				sync1[p] <= pins_raw[p];
				sync2[p] <= sync1[p];
				sync3[p] <= sync2[p];
				for (int b = 0; b < port_width; b++) begin
					if (sync2[p][b] == sync3[p][b]) begin
						pin_level[p][b] <= sync3[p][b];
					end
				end
			end
		end
	end

	// ***********************************
	// apb decode
	// ***********************************
	function automatic logic hit(input logic [addr_width-1:0] a,
	                             input logic [7:0] idx);
		hit = (a == (addr_width'(idx) << word_shift));
	endfunction

	// ***********************************
	// decode helpers
	// ***********************************
	// one-hot pin select; the reserved index selects no pin
	function automatic logic [pin_count-1:0] pin_onehot(
		input logic [2:0] index);
		pin_onehot = '0;
		for (int i = 0; i < pin_count; i++) begin
			if (index == 3'(i)) begin
				pin_onehot[i] = 1'b1;
			end
		end
	endfunction

	// pad decode of one stored mode
	function automatic logic drive_high(input logic [2:0] code);
		drive_high = (code == out_high);
	endfunction

	function automatic logic buffer_on(input logic [1:0] code);
		buffer_on = (code != in_off);
	endfunction

	function automatic logic pull_down_on(input logic [1:0] code);
		pull_down_on = (code == in_pull_down);
	endfunction

	function automatic logic pull_up_on(input logic [1:0] code);
		pull_up_on = (code == in_pull_up);
	endfunction

	// readback word: mode field in place, all other bits zero
	function automatic logic [31:0] cfg_word(input logic [2:0] mode);
		cfg_word = 32'(mode) << mode_lo;
	endfunction

	wire       access      = psel && penable;
	wire       wr          = access && pwrite && pstrb[0];
	wire       hit_p0      = hit(paddr, idx_port0_value);
	wire       hit_p1      = hit(paddr, idx_port1_value);
	wire       hit_p2      = hit(paddr, idx_port2_value);
	wire       hit_p3      = hit(paddr, idx_port3_value);
	wire       hit_cfg     = hit(paddr, idx_port3_pin_mode_config);
	wire       mapped      = hit_p0 | hit_p1 | hit_p2 | hit_p3 | hit_cfg;
	wire [7:0] wbyte       = pwdata[7:0];
	wire [2:0] w_mode      = wbyte[mode_hi:mode_lo];
	wire       w_dir       = wbyte[dir_bit];
	wire       w_latch     = wbyte[latch_bit];
	wire [2:0] w_index     = wbyte[index_hi:index_lo];
	wire       cfg_wr      = wr && hit_cfg;
	wire       latch_wr    = cfg_wr && w_latch;
	wire       mode_wr     = cfg_wr && !w_latch;
	wire       index_ok    = (w_index != index_reserved);
	wire       mode_ok     = mode_wr && index_ok;
	wire       read_setup  = psel && !penable && !pwrite;

	// ***********************************
	// per-pin mode strobes
	// ***********************************
	wire [pin_count-1:0] w_pin_sel = pin_onehot(w_index);
	wire [pin_count-1:0] out_wr    = mode_ok && !w_dir ? w_pin_sel : '0;
	wire [pin_count-1:0] in_wr     = mode_ok && w_dir ? w_pin_sel : '0;

	// no wait states: every access ends in one cycle
	assign pready  = 1'b1;
	// unmapped access answers at once with an error
	assign pslverr = access && !mapped;

	// ***********************************
	// port value registers
	// ***********************************
	logic [port_width-1:0] port_value [4];
	wire                   port_hit [4];
	wire                   port_wr  [4];

	assign port_hit[0] = hit_p0;
	assign port_hit[1] = hit_p1;
	assign port_hit[2] = hit_p2;
	assign port_hit[3] = hit_p3;

	// only byte lane 0 carries port data
	for (genvar p = 0; p < 4; p++) begin : g_port_wr
		assign port_wr[p] = wr && port_hit[p];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < 4; p++) begin
				port_value[p] <= port_width'(port_value_reset);
			end
		end else begin
			for (int p = 0; p < 4; p++) begin
				// writes land at the access edge
				if (port_wr[p]) begin
					port_value[p] <= pwdata[port_width-1:0];
				end
			end
		end
	end

	assign port0_out = port_value[0];
	assign port1_out = port_value[1];
	assign port2_out = port_value[2];
	assign port3_out = port_value[3];

	// ***********************************
	// pin mode store and readback pointer
	// ***********************************
	logic [2:0] out_mode [pin_count];
	logic [1:0] in_mode  [pin_count];
	logic [2:0] saved_index;
	logic       saved_dir;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < pin_count; i++) begin
				out_mode[i] <= config_reset[mode_hi:mode_lo];
				in_mode[i]  <= config_reset[mode_hi-1:mode_lo];
			end
		end else begin
			// reserved index gives no strobe, so nothing moves
			for (int i = 0; i < pin_count; i++) begin
				if (out_wr[i]) begin
					out_mode[i] <= w_mode;
				end
				if (in_wr[i]) begin
					in_mode[i] <= w_mode[1:0];
				end
			end
		end
	end

	// reset pointer names output side of pin 0
	// pointer only moves on a latch write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saved_index <= config_reset[index_hi:index_lo];
			saved_dir   <= config_reset[dir_bit];
		end else if (latch_wr) begin
			saved_index <= w_index;
			saved_dir   <= w_dir;
		end
	end

	// ***********************************
	// pad control decode
	// ***********************************
	// illegal output codes still stored; only high drive code lifts drive
	wire [pin_count-1:0] pad_high;
	wire [pin_count-1:0] pad_in_on;
	wire [pin_count-1:0] pad_pull_down;
	wire [pin_count-1:0] pad_pull_up;

	for (genvar i = 0; i < pin_count; i++) begin : g_pad
		assign pad_high[i]      = drive_high(out_mode[i]);
		assign pad_in_on[i]     = buffer_on(in_mode[i]);
		assign pad_pull_down[i] = pull_down_on(in_mode[i]);
		assign pad_pull_up[i]   = pull_up_on(in_mode[i]);
	end

	assign port3_out_mode = out_mode;
	assign port3_in_mode  = in_mode;
	assign port3_controls = {pad_high, pad_in_on, pad_pull_down, pad_pull_up};

	// ***********************************
	// read path
	// ***********************************
	logic [2:0] read_mode;

	// reserved pointer reads as mode zero
	wire [pin_count-1:0] r_pin_sel = pin_onehot(saved_index);

	always_comb begin
		read_mode = '0;
		for (int i = 0; i < pin_count; i++) begin
			if (r_pin_sel[i]) begin
				read_mode = saved_dir ? {1'b0, in_mode[i]} : out_mode[i];
			end
		end
	end

	function automatic logic [31:0] widen(input logic [port_width-1:0] v);
		widen = 32'(v);
	endfunction

	// port reads show the synchronised pin levels
	wire [31:0] read_mux =
		hit_p0  ? widen(pin_level[0]) :
		hit_p1  ? widen(pin_level[1]) :
		hit_p2  ? widen(pin_level[2]) :
		hit_p3  ? widen(pin_level[3]) :
		hit_cfg ? cfg_word(read_mode) :
		32'h0000_0000;

	// ***********************************
	// registered read data
	// ***********************************
	// captured in the setup phase, so pready stays high with data
	// from a flop; idle and write cycles read as zero
	logic [31:0] read_word;
	wire  [31:0] next_read_word = read_setup ? read_mux : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_word <= 32'h0000_0000;
		end else begin
			read_word <= next_read_word;
		end
	end

	assign prdata = read_word;

endmodule

// [port_pins_model.sv]
// pin model: outside circuitry lets each pin follow its port driver
module port_pins_model (
	input  wire logic [7:0] drive0,
	input  wire logic [7:0] drive1,
	input  wire logic [7:0] drive2,
	input  wire logic [7:0] drive3,
	output logic      [7:0] level0,
	output logic      [7:0] level1,
	output logic      [7:0] level2,
	output logic      [7:0] level3
);
	timeunit 1ns;
	timeprecision 1ps;
	// no load on the pins, so each one settles at the driven level
	assign level0 = drive0;
	assign level1 = drive1;
	assign level2 = drive2;
	assign level3 = drive3;
endmodule

// [port_pin_mode_config_properties.sv]
// checker for bus timing, mode storage and pin control decoding
module port_pin_mode_config_properties
	import port_cfg_pkg::*;
(
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [3:0]            pstrb,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [7:0]            port0_out,
	input wire logic [2:0]            port3_out_mode [pin_count],
	input wire logic [1:0]            port3_in_mode  [pin_count],
	input wire pin_controls_t         port3_controls
);
	logic          acc;
	logic          cw;
	pin_controls_t xc;
	assign acc = psel && penable;
	assign cw = acc && pwrite && pstrb[0] && paddr == 12'h23c;
	always_comb begin
		xc = '0;
		for (int i = 0; i < pin_count; i++) begin
			xc.high_drive[i] = port3_out_mode[i] == out_high;
			xc.input_enable[i] = port3_in_mode[i] != in_off;
			xc.pull_down[i] = port3_in_mode[i] == in_pull_down;
			xc.pull_up[i] = port3_in_mode[i] == in_pull_up;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_mw; cw && !pwdata[3] && pwdata[2:0] != 3'h7; endsequence
	property p_rdy; acc |-> pready; endproperty
	property p_idle; !acc |-> prdata == 32'h0; endproperty
	property p_err;
		acc && !(paddr inside {12'h200, 12'h23c, 12'h240, 12'h280, 12'h2c0})
		|-> pslverr && prdata == 32'h0;
	endproperty
	property p_wr0;
		acc && pwrite && pstrb[0] && paddr == 12'h200
		|=> port0_out == $past(pwdata[7:0]);
	endproperty
	property p_out; s_mw ##0 !pwdata[4]
		|=> port3_out_mode[$past(pwdata[2:0])] == $past(pwdata[7:5]); endproperty
	property p_in; s_mw ##0 pwdata[4]
		|=> port3_in_mode[$past(pwdata[2:0])] == $past(pwdata[6:5]); endproperty
	property p_hold; cw && (pwdata[3] || pwdata[2:0] == 3'h7)
		|=> $stable(port3_controls); endproperty
	property p_ctl; port3_controls == xc; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	a_idle: assert property (p_idle) else $error("read data not 0");
	a_err: assert property (p_err) else $error("unmapped ok");
	a_wr0: assert property (p_wr0) else $error("port0 wrong");
	a_out: assert property (p_out) else $error("out mode");
	a_in: assert property (p_in) else $error("in mode");
	a_hold: assert property (p_hold) else $error("mode moved");
	a_ctl: assert property (p_ctl) else $error("bad decode");
endmodule
bind port_pin_mode_config port_pin_mode_config_properties u_props (
	.pclk           (pclk),
	.presetn        (presetn),
	.psel           (psel),
	.penable        (penable),
	.pwrite         (pwrite),
	.paddr          (paddr),
	.pwdata         (pwdata),
	.pstrb          (pstrb),
	.prdata         (prdata),
	.pready         (pready),
	.pslverr        (pslverr),
	.port0_out      (port0_out),
	.port3_out_mode (port3_out_mode),
	.port3_in_mode  (port3_in_mode),
	.port3_controls (port3_controls)
);

// [port_pin_mode_config_tb_top.sv]
// testbench for the port value and pin mode registers
module port_pin_mode_config_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import port_cfg_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, rd, d, seed;
	logic [3:0]    pstrb;
	logic [7:0]    pi [4];
	logic [7:0]    po [4];
	logic [2:0]    om_d [pin_count];
	logic [1:0]    im_d [pin_count];
	pin_controls_t ctl;
	logic [2:0]    om [8];
	logic [1:0]    im [8];
	logic [2:0]    sidx;
	logic          sdir;
	int            n_mismatch, compares;
	port_pin_mode_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port0_in(pi[0]), .port1_in(pi[1]), .port2_in(pi[2]),
		.port3_in(pi[3]), .port0_out(po[0]), .port1_out(po[1]),
		.port2_out(po[2]), .port3_out(po[3]), .port3_out_mode(om_d),
		.port3_in_mode(im_d), .port3_controls(ctl));
	port_pins_model PINS (.drive0(po[0]), .drive1(po[1]), .drive2(po[2]),
		.drive3(po[3]), .level0(pi[0]), .level1(pi[1]), .level2(pi[2]),
		.level3(pi[3]));
	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function logic [11:0] pa(input int p);
		return p == 0 ? 12'h200 : 12'h200 + 12'(p) * 12'h40;
	endfunction
	function logic [31:0] xcfg();
		if (sidx == 3'h7) return 32'h0;
		return {24'h0, sdir ? {1'b0, im[sidx]} : om[sidx], 5'h0};
	endfunction
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task report_and_stop;
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		seed = 32'hc22e;
		{sidx, sdir} = '0;
		for (int i = 0; i < 8; i++) {om[i], im[i]} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		repeat (8) @(posedge pclk);
		apb(0, 12'h23c, 0);
		chk("config reset", xcfg(), rd);
		for (int p = 0; p < 4; p++) begin
			apb(0, pa(p), 0);
			chk("port reset", 32'hff, rd);
			seed = xs(seed);
			apb(1, pa(p), seed);
			repeat (6) @(posedge pclk);
			apb(0, pa(p), 0);
			chk("port value", {24'h0, seed[7:0]}, rd);
		end
		for (int k = 0; k < 80; k++) begin
			seed = xs(seed);
			d = seed;
			// software only ever writes the two legal output codes
			if (!d[4]) d[7:5] = d[5] ? out_high : out_normal;
			apb(1, 12'h23c, d);
			if (d[3]) {sidx, sdir} = {d[2:0], d[4]};
			else if (d[2:0] != 3'h7 && d[4]) im[d[2:0]] = d[6:5];
			else if (d[2:0] != 3'h7) om[d[2:0]] = d[7:5];
			apb(0, 12'h23c, 0);
			chk("config read", xcfg(), rd);
			chk("config error", 32'h0, {31'h0, er});
		end
		apb(0, 12'h204, 0);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped error", 32'h1, {31'h0, er});
		report_and_stop;
	end
endmodule
